// ==== rtl/mtd_map.vh ====
`ifndef MTD_MAP_VH
`define MTD_MAP_VH
// Register offsets
`define MTD_OFF_LIMIT      8'h5A
`define MTD_OFF_CTRL_ONE   8'h5B
`define MTD_OFF_CTRL_TWO   8'h5C
`define MTD_OFF_CTRL_THREE 8'h5D
`define MTD_OFF_STATUS     8'h5E
// Reset values
`define MTD_RST_LIMIT      8'h00
`define MTD_RST_CTRL_ONE   8'h00
`define MTD_RST_CTRL_TWO   8'h00
`define MTD_RST_CTRL_THREE 8'h00
// Control one fields
`define MTD_C1_ACAL        7
`define MTD_C1_DEGAUSS     6
`define MTD_C1_ONESHOT     5
`define MTD_C1_OSR_HI      4
`define MTD_C1_OSR_LO      2
`define MTD_C1_HMS_HI      1
`define MTD_C1_HMS_LO      0
// Control two fields
`define MTD_C2_HYB_AINC    5
`define MTD_C2_MM_DIS      4
`define MTD_C2_MM_DIS_THS  3
`define MTD_C2_MM_RST      2
`define MTD_C2_RCNT_HI     1
`define MTD_C2_RCNT_LO     0
// Control three fields
`define MTD_C3_RAW         7
// Sensor select codes
`define MTD_HMS_ACCEL      2'h0
`define MTD_HMS_MAG        2'h1
`define MTD_HMS_HYBRID     2'h3
// Degauss interval codes and counts
`define MTD_RCNT_EVERY     2'h0
`define MTD_RCNT_16        2'h1
`define MTD_RCNT_512       2'h2
`define MTD_RCNT_OFF       2'h3
`define MTD_DG_PERIOD_16   10'h00F
`define MTD_DG_PERIOD_512  10'h1FF
// Min/max reset values
`define MTD_MIN_INIT       16'h7FFF
`define MTD_MAX_INIT       16'h8000
// Burst wrap addresses
`define MTD_ADDR_WRAP_SLOW 8'h06
`define MTD_ADDR_WRAP_FAST 8'h05
`define MTD_ADDR_MAG_OUT   8'h33
// Degauss pulse length in clocks
`define MTD_DG_CYCLES      4'h8
`endif

// ==== rtl/mtd_ctrl.v ====
// Summary of operation
// [RQ1] Flag event when counter equals limit
// [RQ2] Counter saturates at programmed limit
// [RQ3] One count step per sample tick
// [RQ4] Hybrid mode doubles the step length
// [RQ5] Condition false: clear or decrement counter
// [RQ6] Condition true: increment counter by one
// [RQ7] Autocal loads offset (max plus min)/2
// [RQ8] Offsets applied only when raw bit low
// [RQ9] Degauss one-shot bit self-clears when done
// [RQ10] One-shot measure in Standby, then self-clear; the bit clears only on a magnetic sample, so never with sensor code 0 or 2
// [RQ11] Output rate from oversample and data rate
// [RQ12] Sensor select: accel, mag, hybrid codes
// [RQ13] Hybrid samples each sensor at half rate
// [RQ14] Hybrid maps magnetic and accel copies
// [RQ15] Burst wraps 0x06 to 0x33, slow read
// [RQ16] Burst wraps 0x05 to 0x33, fast read
// [RQ17] Track per-axis min/max each sample
// [RQ18] Event may stop min/max tracking
// [RQ19] Min/max reset loads 0x7FFF and 0x8000
// [RQ20] Degauss every cycle, 16 or 512
// [RQ21] Code 3: degauss on activate or one-shot
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`include "mtd_map.vh"
module mtd_ctrl (
   input  wire        clk_in,         // System clock
   input  wire        sys_rst_in,     // Async reset, active high
   input  wire        clk_en_in,      // Freezes all state when low
   input  wire [7:0]  reg_addr_in,    // Register address
   input  wire [7:0]  reg_wdata_in,   // Write data
   input  wire        reg_wr_in,      // Write strobe
   input  wire        reg_rd_in,      // Read strobe
   output reg  [7:0]  reg_rdata_out,  // Read data, cycle after strobe
   input  wire        odr_tick_in,    // System sample tick
   input  wire        active_in,      // Device in Active mode
   input  wire        ths_cond_in,    // Threshold condition of sample
   input  wire        dbcnt_clr_in,   // Clear mode of debounce counter
   input  wire [47:0] mag_raw_in,     // Raw samples z,y,x 16 bits each
   input  wire        fast_read_in,   // Fast-read mode
   input  wire [7:0]  burst_addr_in,  // Current burst address
   output reg  [7:0]  burst_next_out, // Next burst address
   output reg         ths_event_out,  // Threshold event flag
   output reg         mag_sample_out, // Magnetic sample strobe
   output reg         acc_sample_out, // Accelerometer sample strobe
   output reg         degauss_out,    // Sensor reset pulse
   output reg  [2:0]  osr_out,        // Oversample ratio in use
   output reg         mag_en_out,     // Magnetometer enabled
   output reg         acc_en_out,     // Accelerometer enabled
   output reg         hyb_map_out,    // Hybrid output map active
   output reg  [47:0] mag_corr_out,   // Corrected samples z,y,x
   output reg  [47:0] mag_off_out     // Offsets z,y,x
);
   //--------------------------------------------
   // Usage notes
   //--------------------------------------------
   // All inputs come from logic on this clock, so none is synchronised
   // Sample tick is one clock wide; a longer tick counts several samples
   // Clock enable low freezes every register, bus port included
   // Register writes take effect on the edge that samples the strobe
   // Read data stand for one cycle after the read strobe, zero otherwise
   // Status byte is read only; writes to it are dropped
   // Debounce counter moves only on magnetic samples
   // Hybrid mode gives every other tick to the magnetometer
   // Hence the debounce step doubles in hybrid mode
   // Event flag is a level, one cycle behind the counter
   // Lowering the limit below the count clamps it on the next sample with the condition true
   // Clear mode is sampled at each magnetic sample only
   // Degauss pulse length is fixed by a header count
   // A pulse in progress masks any new degauss request
   // Activation degausses whenever the magnetometer is enabled
   // Interval counter counts magnetic samples, not clocks
   // Interval counter keeps its value across interval changes
   // Self-clearing bits lose to a host write in the same cycle
   // One-shot measure runs only while the device is in Standby
   // In Active the one-shot bit stays set and does nothing
   // Min/max reset lands two cycles after the request bit
   // Request bit drops in the cycle the reset lands
   // Reset of min/max beats tracking in the same cycle
   // Offsets use min/max from before the current sample
   // Midpoint rounds towards minus infinity for odd sums
   // Offset removal wraps in 16 bits like the samples
   // Raw bit bypasses offsets but calibration still runs
   // Tracking stop clears on a min/max reset or bit low
   // Burst next address follows the current one by a cycle
   // Burst jump applies only with the hybrid wrap bit set
   // Sensor code 2 enables neither sensor
   //--------------------------------------------
   // Registers and state
   //--------------------------------------------
   reg  [7:0]  limit_reg;
   reg  [7:0]  ctrl_one_reg;
   reg  [7:0]  ctrl_two_reg;
   reg  [7:0]  ctrl_three_reg;
   reg  [7:0]  dbcnt_reg;
   reg         phase_reg;
   reg  [9:0]  dg_cnt_reg;
   reg  [3:0]  dg_len_reg;
   reg         active_d_reg;
   reg         mm_stop_reg;
   reg  [47:0] min_reg;
   reg  [47:0] max_reg;
   reg  [47:0] off_reg;
   reg         mm_dirty_reg;
   wire [1:0]  hms = ctrl_one_reg[`MTD_C1_HMS_HI:`MTD_C1_HMS_LO];
   wire        hybrid = (hms == `MTD_HMS_HYBRID);
   wire        mag_on = (hms == `MTD_HMS_MAG) | hybrid;
   wire        one_shot_go = ctrl_one_reg[`MTD_C1_ONESHOT] & ~active_in;
   wire        run = (active_in | ctrl_one_reg[`MTD_C1_ONESHOT]) & odr_tick_in;
   // Hybrid alternates sensors so each sees half the tick rate
   wire        mag_tick = run & mag_on & (~hybrid | ~phase_reg);       // see [RQ13]
   wire        acc_tick = run & (hms == `MTD_HMS_ACCEL | (hybrid & phase_reg));
   wire        wr_one = clk_en_in & reg_wr_in & (reg_addr_in == `MTD_OFF_CTRL_ONE);
   wire        wr_two = clk_en_in & reg_wr_in & (reg_addr_in == `MTD_OFF_CTRL_TWO);
   wire        dg_period_hit;
   wire        dg_start;
   wire        dg_busy = (dg_len_reg != 4'h0);

   //--------------------------------------------
   // Register bus
   //--------------------------------------------
   // Host writes; hardware clears self-clearing bits, a new write wins
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         limit_reg      <= `MTD_RST_LIMIT;
         ctrl_one_reg   <= `MTD_RST_CTRL_ONE;
         ctrl_two_reg   <= `MTD_RST_CTRL_TWO;
         ctrl_three_reg <= `MTD_RST_CTRL_THREE;
      end else if (clk_en_in) begin
         if (reg_wr_in && reg_addr_in == `MTD_OFF_LIMIT)
            limit_reg <= reg_wdata_in;
         if (reg_wr_in && reg_addr_in == `MTD_OFF_CTRL_THREE)
            ctrl_three_reg <= reg_wdata_in;
         if (wr_one) begin
            ctrl_one_reg <= reg_wdata_in;
         end else begin
            if (dg_len_reg == 4'h1)
               ctrl_one_reg[`MTD_C1_DEGAUSS] <= 1'b0;          // see [RQ9]
            if (mag_tick && one_shot_go)
               ctrl_one_reg[`MTD_C1_ONESHOT] <= 1'b0;          // see [RQ10]
         end
         if (wr_two)
            ctrl_two_reg <= reg_wdata_in;
         else if (mm_dirty_reg)
            ctrl_two_reg[`MTD_C2_MM_RST] <= 1'b0;              // see [RQ19]
      end
   end

   // Read mux, data one cycle after strobe
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         reg_rdata_out <= 8'h00;
      end else if (clk_en_in) begin
         if (reg_rd_in) begin
            case (reg_addr_in)
               `MTD_OFF_LIMIT:      reg_rdata_out <= limit_reg;
               `MTD_OFF_CTRL_ONE:   reg_rdata_out <= ctrl_one_reg;
               `MTD_OFF_CTRL_TWO:   reg_rdata_out <= ctrl_two_reg;
               `MTD_OFF_CTRL_THREE: reg_rdata_out <= ctrl_three_reg;
               `MTD_OFF_STATUS:     reg_rdata_out <= {5'h00, ths_event_out, 1'b0, dbcnt_reg != 8'h00};
               default:             reg_rdata_out <= 8'h00;
            endcase
         end else begin
            reg_rdata_out <= 8'h00;
         end
      end
   end

   //--------------------------------------------
   // Debounce counter
   //--------------------------------------------
   // Steps only on magnetic samples, so the step tracks rate and hybrid
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         dbcnt_reg     <= 8'h00;
         ths_event_out <= 1'b0;
         phase_reg     <= 1'b0;
      end else if (clk_en_in) begin
         if (run && hybrid)
            phase_reg <= ~phase_reg;                           // see [RQ4]
         else if (!hybrid)
            phase_reg <= 1'b0;
         if (mag_tick) begin                                   // see [RQ3]
            if (ths_cond_in) begin
               if (dbcnt_reg < limit_reg)
                  dbcnt_reg <= dbcnt_reg + 8'h01;              // see [RQ6]
               else
                  dbcnt_reg <= limit_reg;                      // see [RQ2]
            end else if (dbcnt_clr_in) begin
               dbcnt_reg <= 8'h00;                             // see [RQ5]
            end else if (dbcnt_reg != 8'h00) begin
               dbcnt_reg <= dbcnt_reg - 8'h01;                 // see [RQ5]
            end
         end
         ths_event_out <= ths_cond_in && (dbcnt_reg == limit_reg); // see [RQ1]
      end
   end

   //--------------------------------------------
   // Degauss scheduling
   //--------------------------------------------
   wire [1:0] rcnt = ctrl_two_reg[`MTD_C2_RCNT_HI:`MTD_C2_RCNT_LO];
   assign dg_period_hit = (rcnt == `MTD_RCNT_EVERY) |
                          (rcnt == `MTD_RCNT_16  && dg_cnt_reg == `MTD_DG_PERIOD_16) |
                          (rcnt == `MTD_RCNT_512 && dg_cnt_reg == `MTD_DG_PERIOD_512);
   assign dg_start = ~dg_busy & ((mag_tick & dg_period_hit) |          // see [RQ20]
                     (ctrl_one_reg[`MTD_C1_DEGAUSS] & ~degauss_out) |
                     (active_in & ~active_d_reg & mag_on));            // see [RQ21]

   // Interval counter, pulse timer and activation edge
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         dg_cnt_reg   <= 10'h000;
         dg_len_reg   <= 4'h0;
         degauss_out  <= 1'b0;
         active_d_reg <= 1'b0;
      end else if (clk_en_in) begin
         active_d_reg <= active_in;
         if (mag_tick)
            dg_cnt_reg <= dg_period_hit ? 10'h000 : dg_cnt_reg + 10'h001;
         if (dg_start) begin
            dg_len_reg  <= `MTD_DG_CYCLES;
            degauss_out <= 1'b1;
         end else if (dg_busy) begin
            dg_len_reg  <= dg_len_reg - 4'h1;                  // see [RQ9]
            degauss_out <= (dg_len_reg != 4'h1);
         end
      end
   end

   //--------------------------------------------
   // Min/max tracking, calibration, offsets
   //--------------------------------------------
   // Per-axis next values; one process below owns every bit
   wire [47:0] min_next;
   wire [47:0] max_next;
   wire [47:0] off_next;
   wire [47:0] corr_next;
   wire        track_en = mag_tick & ~ctrl_two_reg[`MTD_C2_MM_DIS] & ~mm_stop_reg;
   wire        cal_en   = mag_tick & ctrl_one_reg[`MTD_C1_ACAL];

   genvar ax;
   generate
      for (ax = 0; ax < 3; ax = ax + 1) begin : g_axis
         // Signed views of this axis
         wire signed [15:0] raw  = mag_raw_in[ax*16 +: 16];
         wire signed [15:0] mn   = min_reg[ax*16 +: 16];
         wire signed [15:0] mx   = max_reg[ax*16 +: 16];
         // Sign-extended sum cannot overflow before the halving
         wire signed [16:0] sum  = {mx[15], mx} + {mn[15], mn};
         // Offset removal wraps like the sample format
         wire        [15:0] corr = raw - off_reg[ax*16 +: 16];
         // Reset request beats tracking in the same cycle
         assign min_next[ax*16 +: 16] = mm_dirty_reg ? `MTD_MIN_INIT :          // see [RQ19]
                                        ((track_en && raw < mn) ? raw : mn);    // see [RQ17]
         assign max_next[ax*16 +: 16] = mm_dirty_reg ? `MTD_MAX_INIT :
                                        ((track_en && raw > mx) ? raw : mx);
         // Midpoint of tracked extremes
         assign off_next[ax*16 +: 16] = cal_en ? sum[16:1] :
                                        off_reg[ax*16 +: 16];                   // see [RQ7]
         // Raw bit bypasses the offsets
         assign corr_next[ax*16 +: 16] = ctrl_three_reg[`MTD_C3_RAW] ? raw : corr; // see [RQ8]
      end
   endgenerate

   // Tracking registers and corrected samples, all axes at once
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         min_reg      <= {3{`MTD_MIN_INIT}};
         max_reg      <= {3{`MTD_MAX_INIT}};
         off_reg      <= 48'h000000000000;
         mag_corr_out <= 48'h000000000000;
      end else if (clk_en_in) begin
         min_reg <= min_next;
         max_reg <= max_next;
         off_reg <= off_next;
         if (mag_tick)
            mag_corr_out <= corr_next;
      end
   end

   // Min/max reset request and threshold stop
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         mm_dirty_reg <= 1'b0;
         mm_stop_reg  <= 1'b0;
      end else if (clk_en_in) begin
         mm_dirty_reg <= ctrl_two_reg[`MTD_C2_MM_RST] & ~mm_dirty_reg;
         if (!ctrl_two_reg[`MTD_C2_MM_DIS_THS] || mm_dirty_reg)
            mm_stop_reg <= 1'b0;
         else if (ths_event_out)
            mm_stop_reg <= 1'b1;                               // see [RQ18]
      end
   end

   //--------------------------------------------
   // Mode outputs and burst address
   //--------------------------------------------
   // Registered copies of the mode fields and the burst step
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         osr_out        <= 3'h0;
         mag_en_out     <= 1'b0;
         acc_en_out     <= 1'b1;
         hyb_map_out    <= 1'b0;
         mag_sample_out <= 1'b0;
         acc_sample_out <= 1'b0;
         mag_off_out    <= 48'h000000000000;
         burst_next_out <= 8'h00;
      end else if (clk_en_in) begin
         osr_out        <= ctrl_one_reg[`MTD_C1_OSR_HI:`MTD_C1_OSR_LO]; // see [RQ11]
         mag_en_out     <= mag_on;                             // see [RQ12]
         acc_en_out     <= (hms == `MTD_HMS_ACCEL) | hybrid;
         hyb_map_out    <= hybrid;                             // see [RQ14]
         mag_sample_out <= mag_tick;
         acc_sample_out <= acc_tick;
         mag_off_out    <= off_reg;
         if (ctrl_two_reg[`MTD_C2_HYB_AINC] && !fast_read_in &&
             burst_addr_in == `MTD_ADDR_WRAP_SLOW)
            burst_next_out <= `MTD_ADDR_MAG_OUT;               // see [RQ15]
         else if (ctrl_two_reg[`MTD_C2_HYB_AINC] && fast_read_in &&
                  burst_addr_in == `MTD_ADDR_WRAP_FAST)
            burst_next_out <= `MTD_ADDR_MAG_OUT;               // see [RQ16]
         else
            burst_next_out <= burst_addr_in + 8'h01;
      end
   end

endmodule // mtd_ctrl

// ==== bench/mtd_checker.sv ====
`timescale 1ns/1ps
module mtd_checker (
   input wire       clk_in,         // Clock
   input wire       sys_rst_in,     // Reset
   input wire       clk_en_in,      // Run enable
   input wire       reg_rd_in,      // Read strobe
   input wire [7:0] reg_rdata_out,  // Read data
   input wire       odr_tick_in,    // Sample tick
   input wire       ths_cond_in,    // Threshold condition
   input wire       fast_read_in,   // Fast read
   input wire [7:0] burst_addr_in,  // Burst address
   input wire [7:0] burst_next_out, // Next burst address
   input wire       ths_event_out,  // Event flag
   input wire       mag_sample_out, // Mag sample
   input wire       acc_sample_out, // Accel sample
   input wire       degauss_out,    // Degauss pulse
   input wire       mag_en_out,     // Mag enabled
   input wire       acc_en_out,     // Accel enabled
   input wire       hyb_map_out     // Hybrid map
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);
   // ------------------------------
   // Port relations
   // ------------------------------
   a_rdata_idle: assert property (!$past(reg_rd_in) && $past(clk_en_in) |-> reg_rdata_out == 8'h00)
      else $error("read data not zero outside read cycle");
   a_event_cond: assert property (ths_event_out |-> $past(ths_cond_in))
      else $error("event flag without threshold condition");
   a_sample_tick: assert property (mag_sample_out |-> $past(odr_tick_in) || $past(odr_tick_in, 2))
      else $error("mag sample without sample tick");
   a_sensor_gate: assert property (mag_sample_out |-> mag_en_out)
      else $error("mag sample while mag disabled");
   a_no_both: assert property (!(mag_sample_out && acc_sample_out))
      else $error("both sensors sampled at once");
   a_hyb_map: assert property (hyb_map_out == (mag_en_out && acc_en_out))
      else $error("hybrid map disagrees with enables");
   a_dg_length: assert property ($rose(degauss_out) |-> degauss_out[*8] ##1 !degauss_out)
      else $error("degauss pulse length wrong");
   a_wrap_slow: assert property (burst_addr_in == 8'h05 && !fast_read_in |=> burst_next_out == 8'h06)
      else $error("burst left 0x05 wrongly");
   a_burst_step: assert property (burst_addr_in < 8'h05 |=> burst_next_out == $past(burst_addr_in) + 8'h01)
      else $error("burst step wrong");
   c_event: cover property ($rose(ths_event_out));
   c_degauss: cover property ($rose(degauss_out));
   c_jump: cover property (burst_next_out == 8'h33);
endmodule // mtd_checker

bind mtd_ctrl mtd_checker mtd_checker_inst (.clk_in, .sys_rst_in, .clk_en_in, .reg_rd_in,
   .reg_rdata_out, .odr_tick_in, .ths_cond_in, .fast_read_in, .burst_addr_in, .burst_next_out,
   .ths_event_out, .mag_sample_out, .acc_sample_out, .degauss_out, .mag_en_out, .acc_en_out,
   .hyb_map_out);

// ==== bench/mtd_host.sv ====
`timescale 1ns/1ps
module mtd_host (
   input  wire       clk_in,    // Clock
   input  wire [7:0] rdata_in,  // Read data
   output reg  [7:0] addr_out,  // Address
   output reg  [7:0] wdata_out, // Write data
   output reg        wr_out,    // Write strobe
   output reg        rd_out     // Read strobe
);
   // Idle bus
   initial begin
      addr_out = 8'h00;
      wdata_out = 8'h00;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end
   // One-cycle write
   task wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge clk_in);
      wr_out <= 1'b0;
   endtask
   // One-cycle read, data in next cycle
   task rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge clk_in);
      rd_out <= 1'b0;
      @(posedge clk_in);
      d = rdata_in;
   endtask
endmodule // mtd_host

// ==== bench/mag_threshold_debounce_ctrl_bench.sv ====
`timescale 1ns/1ps
module mag_threshold_debounce_ctrl_bench;
   logic        clk_in = 1'b0, sys_rst_in = 1'b1, clk_en_in = 1'b1, odr_tick_in = 1'b0;
   logic        active_in = 1'b1, ths_cond_in = 1'b0, dbcnt_clr_in = 1'b0, fast_read_in = 1'b0;
   logic [7:0]  burst_addr_in = 8'h00;
   logic [47:0] mag_raw_in = 48'h0;
   wire  [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out, burst_next_out;
   wire         reg_wr_in, reg_rd_in, ths_event_out, mag_sample_out, acc_sample_out;
   wire         degauss_out, mag_en_out, acc_en_out, hyb_map_out;
   wire  [2:0]  osr_out;
   wire  [47:0] mag_corr_out, mag_off_out;
   int          mismatches = 0, samples_checked = 0, n_mag = 0, n_acc = 0, n_dg = 0;
   logic        dg_q = 1'b0;
   integer      seed = 32'h8FDAEF3B;
   logic [7:0]  b_addr [5] = '{8'h04, 8'h05, 8'h06, 8'h05, 8'h06};
   logic [7:0]  b_exp [5] = '{8'h05, 8'h06, 8'h33, 8'h33, 8'h07};
   logic        b_fast [5] = '{0, 0, 0, 1, 0};
   int          db_n [7] = '{2, 2, 2, 1, 2, 1, 2};
   logic        db_c [7] = '{1, 1, 1, 0, 1, 0, 1};
   logic        db_m [7] = '{0, 0, 0, 0, 0, 1, 1};
   logic        db_e [7] = '{0, 1, 1, 0, 1, 0, 0};

   mtd_ctrl mtd_ctrl_inst (.clk_in, .sys_rst_in, .clk_en_in, .reg_addr_in, .reg_wdata_in,
      .reg_wr_in, .reg_rd_in, .reg_rdata_out, .odr_tick_in, .active_in, .ths_cond_in,
      .dbcnt_clr_in, .mag_raw_in, .fast_read_in, .burst_addr_in, .burst_next_out,
      .ths_event_out, .mag_sample_out, .acc_sample_out, .degauss_out, .osr_out,
      .mag_en_out, .acc_en_out, .hyb_map_out, .mag_corr_out, .mag_off_out);
   mtd_host mtd_host_inst (.clk_in, .rdata_in(reg_rdata_out), .addr_out(reg_addr_in),
      .wdata_out(reg_wdata_in), .wr_out(reg_wr_in), .rd_out(reg_rd_in));

   // Clock and pulse counters
   initial forever #2.5 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      n_mag <= n_mag + (mag_sample_out === 1'b1);
      n_acc <= n_acc + (acc_sample_out === 1'b1);
      n_dg <= n_dg + (degauss_out === 1'b1 && !dg_q);
      dg_q <= (degauss_out === 1'b1);
   end
   task chk(input string nm, input logic [47:0] e, input logic [47:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Sample ticks ten clocks apart
   task tick(input int n, input logic c);
      repeat (n) begin
         @(posedge clk_in);
         odr_tick_in <= 1'b1;
         ths_cond_in <= c;
         @(posedge clk_in);
         odr_tick_in <= 1'b0;
         repeat (8) @(posedge clk_in);
      end
   endtask
   task stop_test;
      if (mismatches == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (10000) @(posedge clk_in);
      mismatches++;
      stop_test;
   end

   // Main sequence
   initial begin
      logic [7:0]  d;
      logic [47:0] raw, off, e_off, c;
      int          m0, a0, v, mx [3], mn [3];
      repeat (5) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      foreach (b_exp[i]) begin
         mtd_host_inst.rd_reg(i == 4 ? 8'h10 : 8'h5A + 8'(i % 3), d);
         chk("reset value", 48'h0, 48'(d));
      end
      for (int i = 0; i < 3; i++) begin
         d = {3'h0, 3'($random(seed)), 2'(i == 2 ? 3 : i)};
         mtd_host_inst.wr_reg(8'h5B, d);
         m0 = n_mag;
         a0 = n_acc;
         tick(4, 1'b0);
         chk("oversample", 48'(d[4:2]), 48'(osr_out));
         chk("hybrid map", 48'(i == 2), 48'(hyb_map_out));
         chk("mag samples", 48'(i == 0 ? 0 : (i == 2 ? 2 : 4)), 48'(n_mag - m0));
         chk("acc samples", 48'(i == 1 ? 0 : (i == 2 ? 2 : 4)), 48'(n_acc - a0));
      end
      mtd_host_inst.wr_reg(8'h5B, 8'h01);
      for (int i = 0; i < 4; i++) begin
         mtd_host_inst.wr_reg(8'h5C, 8'(i));
         m0 = n_dg;
         tick(i == 1 ? 32 : (i == 2 ? 520 : 4), 1'b0);
         chk("degauss count", 48'(i == 0 ? 4 : (i == 1 ? 2 : (i == 2 ? 1 : 0))), 48'(n_dg - m0));
      end
      m0 = n_dg;
      active_in <= 1'b0;
      repeat (4) @(posedge clk_in);
      active_in <= 1'b1;
      repeat (20) @(posedge clk_in);
      chk("degauss on activate", 48'(1), 48'(n_dg - m0));
      mtd_host_inst.wr_reg(8'h5B, 8'h41);
      repeat (20) @(posedge clk_in);
      mtd_host_inst.rd_reg(8'h5B, d);
      chk("degauss one-shot", 48'(2), 48'(n_dg - m0));
      chk("degauss bit", 48'(8'h01), 48'(d));
      active_in <= 1'b0;
      mtd_host_inst.wr_reg(8'h5B, 8'h21);
      m0 = n_mag;
      tick(3, 1'b0);
      mtd_host_inst.rd_reg(8'h5B, d);
      chk("one-shot samples", 48'(1), 48'(n_mag - m0));
      chk("one-shot bit", 48'(8'h01), 48'(d));
      active_in <= 1'b1;
      mtd_host_inst.wr_reg(8'h5A, 8'h03);
      foreach (db_n[i]) begin
         dbcnt_clr_in <= db_m[i];
         tick(db_n[i], db_c[i]);
         chk("threshold event", 48'(db_e[i]), 48'(ths_event_out));
      end
      mtd_host_inst.wr_reg(8'h5C, 8'h07);
      mtd_host_inst.wr_reg(8'h5B, 8'h81);
      for (int i = 0; i < 6; i++) begin
         for (int k = 0; k < 3; k++) raw[k*16 +: 16] = 16'($random(seed) & 32'h3FFE);
         mag_raw_in <= raw;
         tick(1, 1'b0);
         if (i > 0) chk("offset", off, mag_off_out);
         e_off = off;
         for (int k = 0; k < 3; k++) begin
            v = int'(raw[k*16 +: 16]);
            if (i == 0 || v > mx[k]) mx[k] = v;
            if (i == 0 || v < mn[k]) mn[k] = v;
            off[k*16 +: 16] = 16'((mx[k] + mn[k]) / 2);
         end
      end
      mtd_host_inst.wr_reg(8'h5B, 8'h01);
      tick(1, 1'b0);
      for (int k = 0; k < 3; k++) c[k*16 +: 16] = raw[k*16 +: 16] - e_off[k*16 +: 16];
      chk("corrected", c, mag_corr_out);
      mtd_host_inst.wr_reg(8'h5D, 8'h80);
      tick(1, 1'b0);
      chk("raw output", raw, mag_corr_out);
      mtd_host_inst.wr_reg(8'h5C, 8'h23);
      foreach (b_addr[i]) begin
         if (i == 4) mtd_host_inst.wr_reg(8'h5C, 8'h03);
         burst_addr_in <= b_addr[i];
         fast_read_in <= b_fast[i];
         repeat (2) @(posedge clk_in);
         #1 chk("burst next", 48'(b_exp[i]), 48'(burst_next_out));
      end
      stop_test;
   end
endmodule // mag_threshold_debounce_ctrl_bench
